// ==== hdl/pclm_pkg.sv ====
// Purpose: Shared constants and carriers for the pen clip and lost-mode supervisor
// Assumes: 24-bit signed plotter coordinates, 32-bit APB data
// Notes:   Command and key codes are arbitrary local encodings
package pclm_pkg;
  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [7:0] PCLM_CTRL_OFS   = 8'h00; // Cmd code, go, key
  localparam logic [7:0] PCLM_XIN_OFS    = 8'h04; // Coordinate X operand
  localparam logic [7:0] PCLM_YIN_OFS    = 8'h08; // Coordinate Y operand
  localparam logic [7:0] PCLM_WLL_OFS    = 8'h0C; // Window lower-left {y,x} 16b each
  localparam logic [7:0] PCLM_WUR_OFS    = 8'h10; // Window upper-right
  localparam logic [7:0] PCLM_STAT_OFS   = 8'h14; // Status
  localparam logic [7:0] PCLM_POSX_OFS   = 8'h18; // Current X
  localparam logic [7:0] PCLM_POSY_OFS   = 8'h1C; // Current Y
  localparam logic [7:0] PCLM_MOVE_OFS   = 8'h20; // Last motion step; not decoded on reads, returns zero
  // ==========================================================
  // Field positions and values
  // ==========================================================
  localparam int         PCLM_GO_BIT     = 8;     // CTRL: start command
  localparam int         PCLM_LAST_BIT   = 9;     // CTRL: last pair of instruction
  localparam int         PCLM_SCALE_BIT  = 10;    // CTRL: operand overflowed scaling
  localparam int         PCLM_KEY_LSB    = 16;    // CTRL: front-panel key code
  localparam logic [7:0] PCLM_ERR_NONE   = 8'h00;
  localparam logic [7:0] PCLM_ERR_UNREC  = 8'h01;
  localparam logic [7:0] PCLM_ERR_PARAM  = 8'h03;
  localparam logic signed [24:0] PCLM_MAXC = 25'sh07FFFFF;  // 2^23-1
  localparam logic signed [24:0] PCLM_MINC = -25'sh0800000; // -2^23
  localparam logic signed [23:0] PCLM_HARD_MIN = 24'sh000000;
  localparam logic signed [23:0] PCLM_HARD_MAX = 24'sh003FFF;
  // ==========================================================
  // Commands and keys
  // ==========================================================
  typedef enum logic [7:0] {
    PCLM_C_NOP = 8'h00, PCLM_C_ABS = 8'h01, PCLM_C_REL = 8'h02, PCLM_C_RAISE = 8'h03,
    PCLM_C_LOWER = 8'h04, PCLM_C_INIT = 8'h05, PCLM_C_ROT = 8'h06, PCLM_C_NRDY = 8'h07,
    PCLM_C_WIN = 8'h08, PCLM_C_DRAW = 8'h09, PCLM_C_ENDI = 8'h0A
  } pclm_cmd_t;
  localparam logic [3:0] PCLM_K_NONE  = 4'h0;
  localparam logic [3:0] PCLM_K_PENDN = 4'h1;
  localparam logic [3:0] PCLM_K_RESET = 4'h2; // Keys 2..7 all clear lost mode
  localparam logic [3:0] PCLM_K_CLRHI = 4'h7;
  // Motion step kinds
  localparam logic [1:0] PCLM_M_NONE  = 2'h0;
  localparam logic [1:0] PCLM_M_UP    = 2'h1;
  localparam logic [1:0] PCLM_M_DOWN  = 2'h2;
  // Carrier for one motion step
  typedef struct packed {
    logic              valid;
    logic [1:0]        kind;
    logic signed [23:0] x;
    logic signed [23:0] y;
  } pclm_move_t;
endpackage

// ==== hdl/pclm_top.sv ====
// Purpose: Clips commanded segments to the window and tracks lost mode
// Assumes: Host parses instruction strings and feeds one pair per command
// Notes:   One step of motion is reported per segment phase via move outputs
`timescale 1ns/1ps
module pclm_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pclk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             pen_down,
  output logic             move_valid,
  output logic      [47:0] move_xy
);
  // ==========================================================
  // Registers
  // ==========================================================
  typedef enum {S_IDLE, S_CALC, S_STEP1, S_STEP2} pclm_st_t;
  pclm_st_t                st_q;
  logic signed [23:0]      xin_q, yin_q, posx_q, posy_q;
  logic signed [23:0]      wx0_q, wy0_q, wx1_q, wy1_q;
  logic signed [23:0]      ix0_q, iy0_q, ix1_q, iy1_q;
  logic [7:0]              err_q;
  logic                    lost_q, pen_prog_q, skip_q, tin_q, fin_q;
  logic                    xov_q, yov_q, last_q;
  logic [7:0]              cmd_q;
  logic                    scale_ovf_q;
  logic [50:0]             move_q;
  logic [31:0]             rdata_q;
  logic                    rdy_q;

  // APB decode: one wait state, writes land on the edge that sees pready
  wire acc   = psel & penable & ~rdy_q & pclk_en;
  wire done  = psel & penable & rdy_q & pclk_en;
  wire wr    = done & pwrite;
  // Operand outside signed 24 bits: upper bits are not a pure sign extension
  wire op_ovf = ~((&pwdata[31:23]) | ~(|pwdata[31:23]));
  wire wr_ct = wr & (paddr == pclm_pkg::PCLM_CTRL_OFS);
  wire go    = wr_ct & pwdata[pclm_pkg::PCLM_GO_BIT] & (st_q == S_IDLE);
  wire [3:0] key = wr_ct ? pwdata[pclm_pkg::PCLM_KEY_LSB +: 4] : pclm_pkg::PCLM_K_NONE;
  wire [7:0] ccode = pwdata[7:0];

  // Range checks on the widened sums
  wire signed [24:0] relx = 25'(posx_q) + 25'(xin_q);
  wire signed [24:0] rely = 25'(posy_q) + 25'(yin_q);
  wire rel_ovf = (relx > pclm_pkg::PCLM_MAXC) | (relx < pclm_pkg::PCLM_MINC) |
                 (rely > pclm_pkg::PCLM_MAXC) | (rely < pclm_pkg::PCLM_MINC);
  wire signed [23:0] tx = (cmd_q == pclm_pkg::PCLM_C_REL) ? relx[23:0] : xin_q;
  wire signed [23:0] ty = (cmd_q == pclm_pkg::PCLM_C_REL) ? rely[23:0] : yin_q;

  // Window membership of old and new point
  function automatic logic inwin(input logic signed [23:0] x, input logic signed [23:0] y,
                                 input logic signed [23:0] a, input logic signed [23:0] b,
                                 input logic signed [23:0] c, input logic signed [23:0] d);
    inwin = (x >= a) & (x <= c) & (y >= b) & (y <= d);
  endfunction
  wire p_in = inwin(posx_q, posy_q, wx0_q, wy0_q, wx1_q, wy1_q);
  wire n_in = inwin(tx, ty, wx0_q, wy0_q, wx1_q, wy1_q);

  // Liang-Barsky style parametric clip, done by bisection-free integer search
  // Trade-off: linear interpolation with one divider per intersection coordinate, kept combinational
  logic signed [47:0] dx, dy;
  logic signed [47:0] tlo_n, tlo_d, thi_n, thi_d;
  logic               hit;
  always_comb begin
    dx    = 48'(tx) - 48'(posx_q);
    dy    = 48'(ty) - 48'(posy_q);
    tlo_n = 48'sh0;
    tlo_d = 48'sh1;
    thi_n = 48'sh1;
    thi_d = 48'sh1;
    hit   = 1'b1;
    // Fractions t = n/d, compared by cross product; four edges
    for (int e = 0; e < 4; e++) begin
      logic signed [47:0] p, q;
      p = 48'sh0;
      q = 48'sh0;
      case (e)
        0: begin p = -dx; q = 48'(posx_q) - 48'(wx0_q); end
        1: begin p =  dx; q = 48'(wx1_q) - 48'(posx_q); end
        2: begin p = -dy; q = 48'(posy_q) - 48'(wy0_q); end
        default: begin p = dy; q = 48'(wy1_q) - 48'(posy_q); end
      endcase
      if (p == 48'sh0) begin
        if (q < 48'sh0) hit = 1'b0;
      end else if (p < 48'sh0) begin
        // Entering edge: t = q/p, raise lower bound
        if (q * tlo_d < tlo_n * p) begin
          tlo_n = -q;
          tlo_d = -p;
        end
      end else begin
        if (q * thi_d < thi_n * p) begin
          thi_n = q;
          thi_d = p;
        end
      end
    end
    if (tlo_n * thi_d > thi_n * tlo_d) hit = 1'b0;
  end
  // Intersection points, truncated toward the start point
  wire signed [47:0] ex0 = 48'(posx_q) + (dx * tlo_n) / tlo_d;
  wire signed [47:0] ey0 = 48'(posy_q) + (dy * tlo_n) / tlo_d;
  wire signed [47:0] ex1 = 48'(posx_q) + (dx * thi_n) / thi_d;
  wire signed [47:0] ey1 = 48'(posy_q) + (dy * thi_n) / thi_d;

  // Physical pen is programmed state gated by lost mode; clipping gates pen_down separately in S_STEP2
  wire phys_down = pen_prog_q & ~lost_q;
  wire known = (ccode <= pclm_pkg::PCLM_C_ENDI);
  wire xy_cmd = (ccode == pclm_pkg::PCLM_C_ABS) | (ccode == pclm_pkg::PCLM_C_REL) |
                (ccode == pclm_pkg::PCLM_C_RAISE) | (ccode == pclm_pkg::PCLM_C_LOWER);

  // ==========================================================
  // APB write side and command control
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Power-on state: pen raised, window at the hard limits
      st_q        <= S_IDLE;
      xin_q       <= '0;
      yin_q       <= '0;
      xov_q       <= 1'b0;
      yov_q       <= 1'b0;
      posx_q      <= '0;
      posy_q      <= '0;
      wx0_q       <= pclm_pkg::PCLM_HARD_MIN;
      wy0_q       <= pclm_pkg::PCLM_HARD_MIN;
      wx1_q       <= pclm_pkg::PCLM_HARD_MAX;
      wy1_q       <= pclm_pkg::PCLM_HARD_MAX;
      ix0_q       <= '0;
      iy0_q       <= '0;
      ix1_q       <= '0;
      iy1_q       <= '0;
      err_q       <= pclm_pkg::PCLM_ERR_NONE;
      lost_q      <= 1'b0;
      pen_prog_q  <= 1'b0;
      skip_q      <= 1'b0;
      last_q      <= 1'b0;
      tin_q       <= 1'b0;
      fin_q       <= 1'b0;
      cmd_q       <= '0;
      scale_ovf_q <= 1'b0;
      move_q      <= '0;
      pen_down    <= 1'b0;
    end else if (pclk_en) begin
      move_q[50] <= 1'b0;
      // Operands keep a range flag, since 24 bits cannot hold the bad value
      if (wr & (paddr == pclm_pkg::PCLM_XIN_OFS)) begin
        xin_q <= pwdata[23:0];
        xov_q <= op_ovf;
      end
      if (wr & (paddr == pclm_pkg::PCLM_YIN_OFS)) begin
        yin_q <= pwdata[23:0];
        yov_q <= op_ovf;
      end
      // Soft window corners
      if (wr & (paddr == pclm_pkg::PCLM_WLL_OFS)) begin
        wx0_q <= 24'(signed'(pwdata[15:0]));
        wy0_q <= 24'(signed'(pwdata[31:16]));
      end
      if (wr & (paddr == pclm_pkg::PCLM_WUR_OFS)) begin
        wx1_q <= 24'(signed'(pwdata[15:0]));
        wy1_q <= 24'(signed'(pwdata[31:16]));
      end
      // Panel keys; a command in the same cycle is applied after them
      if (key == pclm_pkg::PCLM_K_PENDN) begin
        pen_prog_q <= 1'b1;
        pen_down   <= 1'b1;
      end
      if (key >= pclm_pkg::PCLM_K_RESET && key <= pclm_pkg::PCLM_K_CLRHI) begin
        lost_q <= 1'b0;
      end
      if (key == pclm_pkg::PCLM_K_RESET) begin
        pen_prog_q <= 1'b0;
        pen_down   <= 1'b0;
      end
      case (st_q)
        // Command launch: only an idle supervisor takes a go
        S_IDLE: if (go) begin
          cmd_q       <= ccode;
          scale_ovf_q <= pwdata[pclm_pkg::PCLM_SCALE_BIT];
          last_q      <= pwdata[pclm_pkg::PCLM_LAST_BIT];
          if (!known) begin
            err_q <= pclm_pkg::PCLM_ERR_UNREC;
          end else if (ccode == pclm_pkg::PCLM_C_ENDI) begin
            skip_q <= 1'b0;
          end else if (ccode == pclm_pkg::PCLM_C_INIT || ccode == pclm_pkg::PCLM_C_ROT ||
                       ccode == pclm_pkg::PCLM_C_NRDY) begin
            lost_q <= 1'b0;
            if (ccode == pclm_pkg::PCLM_C_INIT) begin
              pen_prog_q <= 1'b0;
              pen_down   <= 1'b0;
              err_q      <= pclm_pkg::PCLM_ERR_NONE;
              wx0_q      <= pclm_pkg::PCLM_HARD_MIN;
              wy0_q      <= pclm_pkg::PCLM_HARD_MIN;
              wx1_q      <= pclm_pkg::PCLM_HARD_MAX;
              wy1_q      <= pclm_pkg::PCLM_HARD_MAX;
            end
          end else if (ccode == pclm_pkg::PCLM_C_DRAW) begin
            // The draw command does nothing while lost
            if (!lost_q) begin
              pen_down <= pen_prog_q;
            end
          end else if (xy_cmd && !skip_q) begin
            if (ccode == pclm_pkg::PCLM_C_RAISE) pen_prog_q <= 1'b0;
            if (ccode == pclm_pkg::PCLM_C_LOWER) pen_prog_q <= 1'b1;
            st_q <= S_CALC;
          end
          if (pwdata[pclm_pkg::PCLM_LAST_BIT]) begin
            skip_q <= 1'b0;
          end
        end
        // One cycle to classify the pair and pick the clip case
        S_CALC: begin
          st_q <= S_IDLE;
          if (cmd_q == pclm_pkg::PCLM_C_REL && lost_q) begin
            // Relative moves are dropped while lost
          end else if (cmd_q == pclm_pkg::PCLM_C_REL && rel_ovf) begin
            lost_q   <= 1'b1;
            pen_down <= 1'b0;
            posx_q   <= relx[23:0];
            posy_q   <= rely[23:0];
          end else if (scale_ovf_q) begin
            lost_q   <= 1'b1;
            pen_down <= 1'b0;
          end else if (xov_q || yov_q) begin
            // Later pairs stay dropped only if the instruction goes on
            err_q  <= pclm_pkg::PCLM_ERR_PARAM;
            skip_q <= ~last_q;
          end else if (lost_q) begin
            // Pen commands only touch the stored status; absolute moves clear
            if (cmd_q == pclm_pkg::PCLM_C_ABS) begin
              lost_q   <= 1'b0;
              posx_q   <= tx;
              posy_q   <= ty;
              tin_q    <= n_in;
              pen_down <= 1'b0;
            end
          end else begin
            posx_q <= tx;
            posy_q <= ty;
            fin_q  <= n_in;
            if (p_in && n_in) begin
              ix1_q <= tx;
              iy1_q <= ty;
              st_q  <= S_STEP2;
              tin_q <= 1'b1;
            end else if (p_in) begin
              ix1_q <= ex1[23:0];
              iy1_q <= ey1[23:0];
              st_q  <= S_STEP2;
              tin_q <= 1'b0;
            end else if (n_in || hit) begin
              ix0_q <= ex0[23:0];
              iy0_q <= ey0[23:0];
              ix1_q <= n_in ? tx : ex1[23:0];
              iy1_q <= n_in ? ty : ey1[23:0];
              tin_q <= n_in;
              st_q <= S_STEP1;
            end
            // Otherwise no motion, position already updated
          end
        end
        S_STEP1: begin
          pen_down <= 1'b0;
          move_q <= {1'b1, pclm_pkg::PCLM_M_UP, ix0_q, iy0_q};
          st_q <= S_STEP2;
        end
        S_STEP2: begin
          pen_down <= phys_down;
          move_q <= {1'b1, phys_down ? pclm_pkg::PCLM_M_DOWN : pclm_pkg::PCLM_M_UP,
                     ix1_q, iy1_q};
          if (!tin_q) pen_down <= 1'b0;
          st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // APB read side
  // ==========================================================
  wire [31:0] rsel =
    (paddr == pclm_pkg::PCLM_STAT_OFS) ?
      {19'h0, fin_q, tin_q, skip_q, pen_prog_q, lost_q, err_q} :
    (paddr == pclm_pkg::PCLM_POSX_OFS) ? {{8{posx_q[23]}}, posx_q} :
    (paddr == pclm_pkg::PCLM_POSY_OFS) ? {{8{posy_q[23]}}, posy_q} :
    (paddr == pclm_pkg::PCLM_XIN_OFS)  ? {8'h0, xin_q} :
    (paddr == pclm_pkg::PCLM_YIN_OFS)  ? {8'h0, yin_q} :
    (paddr == pclm_pkg::PCLM_CTRL_OFS) ? {31'h0, st_q != S_IDLE} : 32'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_q   <= 1'b0;
      rdata_q <= '0;
    end else if (pclk_en) begin
      rdy_q <= acc;
      if (acc) rdata_q <= rsel;
    end
  end
  assign prdata     = rdata_q;
  assign pready     = rdy_q;
  assign pslverr    = 1'b0;
  assign move_valid = move_q[50];
  assign move_xy    = move_q[47:0];

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  lost_pen_up_a: assert property (lost_q && !$past(key == pclm_pkg::PCLM_K_PENDN)
                   && $past(lost_q) |-> !pen_down || $past(pen_down))
    else $error("pen lowered in lost mode");
  rel_ovf_lost_a: assert property (pclk_en && st_q == S_CALC && cmd_q == pclm_pkg::PCLM_C_REL
                   && !lost_q && rel_ovf |=> lost_q)
    else $error("relative overflow missed");
  init_clear_a: assert property (pclk_en && go && ccode == pclm_pkg::PCLM_C_INIT
                   |=> !lost_q && !pen_prog_q)
    else $error("init did not clear");
  unrec_err_a: assert property (pclk_en && go && !known |=> err_q == 8'h01)
    else $error("unknown command not flagged");
  // A bad pair reaching the classify cycle, outside the relative-while-lost and overflow cases
  sequence calc_bad_s;
    pclk_en && st_q == S_CALC && (xov_q || yov_q) && !scale_ovf_q &&
    !(cmd_q == pclm_pkg::PCLM_C_REL && (lost_q || rel_ovf));
  endsequence
  sequence param_err_s;
    err_q == pclm_pkg::PCLM_ERR_PARAM;
  endsequence
  // Bad pair records error three
  range_err_a: assert property (calc_bad_s |=> param_err_s)
    else $error("range error not recorded");
  // Bad pair produces no motion step
  bad_pair_stop_a: assert property (calc_bad_s |=> st_q == S_IDLE)
    else $error("bad pair still moved");
  // In-range absolute move leaves lost mode
  abs_lost_clr_a: assert property (pclk_en && st_q == S_CALC && cmd_q == pclm_pkg::PCLM_C_ABS
                   && lost_q && !scale_ovf_q && !xov_q && !yov_q |=> !lost_q)
    else $error("absolute move kept lost mode");
  // Exit step ends with the pen lifted
  exit_pen_up_a: assert property (pclk_en && st_q == S_STEP2 && !tin_q |=> !pen_down)
    else $error("pen left down after exit");
  // First leg of a clipped entry travels raised
  raised_travel_a: assert property (pclk_en && st_q == S_STEP1 |=> move_valid && !pen_down)
    else $error("entry travel not raised");
endmodule // pclm_top

// ==== verif/pclm_host_model.sv ====
// Purpose: Host-side APB master feeding commands to the pen supervisor
// Assumes: Slave answers with pready; no fixed latency assumed
// Notes:   Released address and data lines show inverted values
`timescale 1ns/1ps
module pclm_host_model (
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata
);
  // ==========================================================
  // Idle bus at time zero
  // ==========================================================
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h00000000;
  end

  // Whole words only; held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    // Released lines must not keep stale values
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule // pclm_host_model

// ==== verif/pclm_top_tb.sv ====
// Purpose: Self-checking bench for the pen clip and lost-mode supervisor
// Assumes: One command at a time, busy polled through CTRL bit 0
// Notes:   Random moves stay inside the power-on window
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); num_errors++; end end
module pclm_top_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pen_down, move_valid;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, p, x, y;
  logic [47:0] move_xy;
  logic [47:0] mq[$];
  int          num_errors, tests_run, seed, i;
  logic [7:0]  cc[11] = '{8'h05, 8'h06, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                          8'h00, 8'h01, 8'h01};
  logic [3:0]  kk[11] = '{4'h0, 4'h0, 4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h0, 4'h0};
  logic [31:0] xs[11] = '{32'h12C, 32'h12C, 32'h12C, 32'h12C, 32'h12C, 32'h12C, 32'h12C,
                          32'h12C, 32'h12C, 32'h12C, 32'h5000};

  // ==========================================================
  // Clock, design, host and step monitor
  // ==========================================================
  always #50 pclk = ~pclk;
  pclm_top pclm_top_inst (.pclk(pclk), .presetn(presetn), .pclk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(), .pen_down(pen_down), .move_valid(move_valid),
    .move_xy(move_xy));
  pclm_host_model pclm_host_model_inst (.pclk(pclk), .prdata(prdata), .pready(pready),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  // Step pulses stand one cycle, so capture every one
  always @(posedge pclk) if (move_valid === 1'b1) mq.push_back(move_xy);

  function automatic logic [47:0] xy(input logic [31:0] a, input logic [31:0] b);
    return {a[23:0], b[23:0]};
  endfunction
  task automatic rw(input logic [7:0] a, output logic [31:0] r);
    pclm_host_model_inst.xfer(1'b0, a, 32'h00000000, r);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    pclm_host_model_inst.xfer(1'b1, a, d, r);
  endtask
  // One pair, then poll busy under a bound
  task automatic run(input logic [7:0] c, input logic [31:0] a, input logic [31:0] b,
                     input logic [3:0] k, input logic last, input logic sc);
    logic [31:0] r;
    int          n;
    wr(pclm_pkg::PCLM_XIN_OFS, a);
    wr(pclm_pkg::PCLM_YIN_OFS, b);
    mq.delete();
    wr(pclm_pkg::PCLM_CTRL_OFS, {12'h000, k, 5'h00, sc, last, 1'b1, c});
    n = 0;
    r = 32'h00000001;
    while (r[0] !== 1'b0 && n < 100) begin
      rw(pclm_pkg::PCLM_CTRL_OFS, r);
      n++;
    end
    if (n >= 100) num_errors++;
  endtask
  task automatic mv(input logic [7:0] c, input logic [31:0] a, input logic [31:0] b);
    run(c, a, b, 4'h0, 1'b1, 1'b0);
  endtask
  task automatic st();
    rw(pclm_pkg::PCLM_STAT_OFS, rd);
  endtask
  task automatic px();
    rw(pclm_pkg::PCLM_POSX_OFS, rd);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog, far beyond the expected run length
  initial begin
    #(100 * 40000);
    num_errors++;
    print_verdict();
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    seed = 39;
    num_errors = 0;
    tests_run = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    st(); `CHK(rd[9:0], 10'h000)
    `CHK(pen_down, 1'b0)
    wr(8'h44, 32'hFFFFFFFF);
    rw(8'h44, rd); `CHK(rd, 32'h00000000)
    $display("test reset done");
    // Segment kinds against the hard window, pen programmed down
    mv(pclm_pkg::PCLM_C_ABS, 32'h64, 32'hC8); `CHK(mq[$], xy(32'h64, 32'hC8))
    mv(pclm_pkg::PCLM_C_LOWER, 32'h64, 32'hC8); `CHK(pen_down, 1'b1)
    mv(pclm_pkg::PCLM_C_ABS, 32'h5000, 32'hC8); `CHK(mq[$], xy(32'h3FFF, 32'hC8))
    `CHK(pen_down, 1'b0)
    mv(pclm_pkg::PCLM_C_ABS, 32'hFFFFFF9C, 32'hC8); `CHK(mq.size(), 2)
    `CHK(mq[0], xy(32'h3FFF, 32'hC8))
    `CHK(mq[1], xy(32'h0, 32'hC8))
    `CHK(pen_down, 1'b0)
    mv(pclm_pkg::PCLM_C_ABS, 32'h64, 32'hC8); `CHK(mq[0], xy(32'h0, 32'hC8))
    `CHK(mq[1], xy(32'h64, 32'hC8))
    `CHK(pen_down, 1'b1)
    $display("test clipping done");
    // Error codes and discarding of later pairs
    mv(8'h0B, 32'h0, 32'h0); st(); `CHK(rd[7:0], 8'h01)
    mv(pclm_pkg::PCLM_C_ABS, 32'h0, 32'hFF7FFFFF); st(); `CHK(rd[7:0], 8'h03)
    mv(8'h0B, 32'h0, 32'h0);
    run(pclm_pkg::PCLM_C_ABS, 32'h800000, 32'h0, 4'h0, 1'b0, 1'b0);
    st(); `CHK(rd[7:0], 8'h03)
    `CHK(mq.size(), 0)
    run(pclm_pkg::PCLM_C_ABS, 32'h12C, 32'h12C, 4'h0, 1'b0, 1'b0);
    px(); `CHK(rd[23:0], 24'h000064)
    mv(pclm_pkg::PCLM_C_ENDI, 32'h0, 32'h0);
    mv(pclm_pkg::PCLM_C_ABS, 32'h12C, 32'h12C); px(); `CHK(rd[23:0], 24'h00012C)
    $display("test errors done");
    // Lost mode entry and every clearing cause
    mv(pclm_pkg::PCLM_C_ABS, 32'h5000, 32'h12C);
    mv(pclm_pkg::PCLM_C_ABS, 32'h7FFFFF, 32'h12C); `CHK(mq.size(), 0)
    px(); `CHK(rd[23:0], 24'h7FFFFF)
    for (i = 0; i < 11; i++) begin
      mv(pclm_pkg::PCLM_C_ABS, 32'h7FFFFF, 32'h12C);
      if (i == 0) run(pclm_pkg::PCLM_C_ABS, 32'h12C, 32'h12C, 4'h0, 1'b1, 1'b1);
      else mv(pclm_pkg::PCLM_C_REL, 32'h1, 32'h0);
      st(); `CHK(rd[8], 1'b1)
      if (i == 1) begin
        px();
        p = rd;
        mv(pclm_pkg::PCLM_C_REL, 32'hFFFFFFFB, 32'h0); px(); `CHK(rd, p)
        mv(pclm_pkg::PCLM_C_LOWER, 32'h12C, 32'h12C); st(); `CHK(rd[9], 1'b1)
        `CHK(rd[8], 1'b1)
        `CHK(pen_down, 1'b0)
        run(pclm_pkg::PCLM_C_NOP, 32'h0, 32'h0, 4'h1, 1'b1, 1'b0); `CHK(pen_down, 1'b1)
      end
      run(cc[i], xs[i], 32'h12C, kk[i], 1'b1, 1'b0);
      st(); `CHK(rd[8], 1'b0)
      if (i == 10) `CHK(mq.size(), 0)
      if (i == 0 || i == 3) begin
        `CHK(rd[9], 1'b0)
        `CHK(pen_down, 1'b0)
      end
    end
    $display("test lost mode done");
    // Random moves inside the power-on window, pen raised
    mv(pclm_pkg::PCLM_C_RAISE, 32'h0, 32'h0);
    for (i = 0; i < 9; i++) begin
      x = (i == 0) ? 32'h3FFF : ($random(seed) & 32'h3FFF);
      y = (i == 0) ? 32'h3FFF : ($random(seed) & 32'h3FFF);
      mv(pclm_pkg::PCLM_C_ABS, x, y); `CHK(mq[$], xy(x, y))
      px(); `CHK(rd[23:0], x[23:0])
    end
    $display("test random done");
    print_verdict();
  end
endmodule // pclm_top_tb
